/* design/dtf_terminal_logic.sv */
// Purpose: Multi-function input decode and output selection for a motor drive
// Assumes: Terminal pins asynchronous; closed reads as 1; 100 MHz sys_clk
// Notes: Analog hold qualify count is a parameter so simulation can shorten it
// Functional notes
// - Code 46 closed disables PID control
// - Code 47 closed clears PID integral
// - Code 48 closed freezes PID integral
// - Code 49 closed bypasses PID ramp time
// - Codes 53-55 add offset frequencies one-three
// - Code 60 open rejects writes except monitor
// - Code 61 closed 100ms samples analog command
// - Power loss clears held command to zero
// - Analog hold conflicts raise setting conflict error
// - Code 65 brakes decel; Run/Jog releases
// - Code 69 open ignores Run, shows indication
// - Run held at enable needs re-cycle
// - Enable opening while running stops motor
// - Code 45 takes state from communications
// - Four outputs, codes 0-149, relay default 0
// - Codes 0-18 select listed status conditions
// - Codes 22-44 select listed status conditions
// - Code 0 closed while producing voltage
// - Code 11 closed while fault active
`timescale 1ns/1ns
`include "dtf_defs.svh"
module dtf_terminal_logic #(
    parameter int AHOLD_CYCLES = `DTF_AHOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [`DTF_NUM_IN-1:0] term_pin,
    input wire logic [`DTF_NUM_IN-1:0] comm_term,
    input wire logic [`DTF_NUM_IN*`DTF_CODE_W-1:0] in_func_select,
    input wire logic [`DTF_NUM_OUT*`DTF_CODE_W-1:0] out_func_select,
    input wire logic pid_enable_setting,
    input wire logic power_loss,
    input wire logic run_cmd,
    input wire logic jog_cmd,
    input wire logic decelerating,
    input wire logic drive_running,
    input wire logic param_write_req,
    input wire logic param_is_freq_monitor,
    input wire dtf_pkg::dtf_freq_t analog_input_first,
    input wire dtf_pkg::dtf_freq_t analog_input_second,
    input wire logic analog_sel_second,
    input wire dtf_pkg::dtf_freq_t offset_frequency_first,
    input wire dtf_pkg::dtf_freq_t offset_frequency_second,
    input wire dtf_pkg::dtf_freq_t offset_frequency_third,
    input wire dtf_pkg::dtf_freq_t freq_command_in,
    input wire dtf_pkg::dtf_status_t drive_status,
    output logic pid_active,
    output logic pid_integral_clear,
    output logic pid_integral_freeze,
    output logic pid_ramp_bypass,
    output dtf_pkg::dtf_freq_t freq_command_out,
    output logic param_write_accept,
    output logic analog_hold_active,
    output logic setting_conflict_error,
    output logic dc_brake_apply,
    output logic run_permit,
    output logic stop_request,
    output logic drive_not_enabled_indication,
    output logic [`DTF_NUM_OUT-1:0] out_terminal
);
    import dtf_pkg::*;

    localparam int CNT_W = $clog2(AHOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] AHOLD_LAST = CNT_W'(AHOLD_CYCLES - 1);

    logic [`DTF_NUM_IN-1:0] sync1_ff; // First stage, read only by sync2
    logic [`DTF_NUM_IN-1:0] sync2_ff; // Stable pin levels
    logic [`DTF_NUM_IN-1:0] term_state; // Pin or comm per terminal
    dtf_func_t func; // Decoded functions
    logic conflict_any; // Any hold-conflicting code assigned
    logic [CNT_W-1:0] ahold_cnt_ff; // Closed-time counter
    logic ahold_ff; // Hold latched
    dtf_freq_t held_freq_ff; // Sampled analog level
    dtf_freq_t nxt_freq; // Command before registering
    dtf_freq_t freq_ff;
    logic dcb_ff; // DC braking state
    dtf_run_state_t run_ff; // Run gating state
    logic stop_ff;
    logic [`DTF_NUM_OUT-1:0] out_ff;

    // Two-flop pin synchroniser
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= term_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // Decode every terminal; any comm mode code moves all terminals to their comm state
    always_comb begin
        dtf_code_t code;
        code = '0;
        func = '0;
        conflict_any = 1'b0;
        term_state = sync2_ff;
        for (int i = 0; i < `DTF_NUM_IN; i++) begin
            code = in_func_select[i*`DTF_CODE_W +: `DTF_CODE_W];
            if (code == `DTF_IN_COMM) begin
                // A terminal that only chose comm mode would decode nothing, so the mode covers all
                term_state = comm_term;
            end
        end
        for (int i = 0; i < `DTF_NUM_IN; i++) begin
            code = in_func_select[i*`DTF_CODE_W +: `DTF_CODE_W];
            case (code)
                `DTF_IN_PID_DIS: func.pid_disable |= term_state[i];
                `DTF_IN_INT_RST: func.integral_reset |= term_state[i];
                `DTF_IN_INT_HOLD: func.integral_hold |= term_state[i];
                `DTF_IN_SOFT_OFF: func.soft_start_bypass |= term_state[i];
                `DTF_IN_OFS1: func.offset_sel[0] |= term_state[i];
                `DTF_IN_OFS2: func.offset_sel[1] |= term_state[i];
                `DTF_IN_OFS3: func.offset_sel[2] |= term_state[i];
                `DTF_IN_PGM_EN: func.program_enable |= term_state[i];
                `DTF_IN_AHOLD: func.analog_hold |= term_state[i];
                `DTF_IN_DCB: func.dc_brake |= term_state[i];
                `DTF_IN_DRV_EN: begin
                    func.drive_enable |= term_state[i];
                    func.drive_enable_assigned = 1'b1;
                end
                default: begin
                end
            endcase
            // Codes that cannot coexist with analog hold
            if (code == `DTF_IN_RAMP_HOLD || code == `DTF_IN_UP || code == `DTF_IN_DOWN ||
                code == `DTF_IN_UP2 || code == `DTF_IN_DOWN2 ||
                (code >= `DTF_IN_OFS1 && code <= `DTF_IN_OFS3)) begin
                conflict_any = 1'b1;
            end
        end
    end

    // Program lockout: no lockout terminal assigned means writes allowed
    logic pgm_assigned;
    always_comb begin
        pgm_assigned = 1'b0;
        for (int i = 0; i < `DTF_NUM_IN; i++) begin
            if (in_func_select[i*`DTF_CODE_W +: `DTF_CODE_W] == `DTF_IN_PGM_EN) begin
                pgm_assigned = 1'b1;
            end
        end
    end

    logic ahold_assigned;
    always_comb begin
        ahold_assigned = 1'b0;
        for (int i = 0; i < `DTF_NUM_IN; i++) begin
            if (in_func_select[i*`DTF_CODE_W +: `DTF_CODE_W] == `DTF_IN_AHOLD) begin
                ahold_assigned = 1'b1;
            end
        end
    end

    // PID control levels straight from decoded terminals
    assign pid_active = pid_enable_setting & ~func.pid_disable;
    assign pid_integral_clear = func.integral_reset;
    assign pid_integral_freeze = func.integral_hold;
    assign pid_ramp_bypass = func.soft_start_bypass;
    // Reads are never blocked; only writes are gated here
    assign param_write_accept = param_write_req &
        (~pgm_assigned | func.program_enable | param_is_freq_monitor);
    assign setting_conflict_error = ahold_assigned & conflict_any;
    assign analog_hold_active = ahold_ff;
    assign freq_command_out = freq_ff;
    assign dc_brake_apply = dcb_ff;
    assign stop_request = stop_ff;
    assign out_terminal = out_ff;
    // Indication only meaningful when an enable terminal is assigned
    assign drive_not_enabled_indication = func.drive_enable_assigned & ~func.drive_enable;
    assign run_permit = (run_ff == DTF_RUN_ACTIVE);

    // Analog hold: terminal must stay closed the full qualify time
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ahold_cnt_ff <= '0;
            ahold_ff <= 1'b0;
            held_freq_ff <= '0;
        end else if (clk_en) begin
            if (power_loss) begin
                ahold_cnt_ff <= '0;
                ahold_ff <= 1'b0;
                held_freq_ff <= '0;
            end else if (!func.analog_hold) begin
                ahold_cnt_ff <= '0;
                ahold_ff <= 1'b0;
            end else if (!ahold_ff) begin
                if (ahold_cnt_ff == AHOLD_LAST) begin
                    ahold_ff <= 1'b1;
                    held_freq_ff <= analog_sel_second ? analog_input_second : analog_input_first;
                end else begin
                    ahold_cnt_ff <= ahold_cnt_ff + 1'b1;
                end
            end
        end
    end

    // Frequency command: held level or live command, plus closed offsets
    always_comb begin
        nxt_freq = ahold_ff ? held_freq_ff : freq_command_in;
        if (func.offset_sel[0]) nxt_freq = nxt_freq + offset_frequency_first;
        if (func.offset_sel[1]) nxt_freq = nxt_freq + offset_frequency_second;
        if (func.offset_sel[2]) nxt_freq = nxt_freq + offset_frequency_third;
    end

    // Registered frequency command, zeroed on power loss
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            freq_ff <= '0;
        end else if (clk_en) begin
            freq_ff <= power_loss ? '0 : nxt_freq;
        end
    end

    // DC braking: engages while decelerating, Run or Jog releases it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dcb_ff <= 1'b0;
        end else if (clk_en) begin
            if (run_cmd || jog_cmd || !func.dc_brake) begin
                dcb_ff <= 1'b0;
            end else if (decelerating) begin
                dcb_ff <= 1'b1;
            end
        end
    end

    // Run gating; a Run already present at enable must be cycled first
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            run_ff <= DTF_RUN_WAIT_CYCLE;
        end else if (clk_en) begin
            case (run_ff)
                DTF_RUN_IDLE: begin
                    if (!func.drive_enable_assigned || func.drive_enable) begin
                        run_ff <= run_cmd ? DTF_RUN_WAIT_CYCLE : DTF_RUN_ACTIVE;
                    end
                end
                DTF_RUN_ACTIVE: begin
                    if (func.drive_enable_assigned && !func.drive_enable) begin
                        run_ff <= DTF_RUN_IDLE;
                    end
                end
                DTF_RUN_WAIT_CYCLE: begin
                    if (func.drive_enable_assigned && !func.drive_enable) begin
                        run_ff <= DTF_RUN_IDLE;
                    end else if (!run_cmd) begin
                        run_ff <= DTF_RUN_ACTIVE;
                    end
                end
                default: run_ff <= DTF_RUN_IDLE;
            endcase
        end
    end

    // Stop request follows the stop method outside; asserted while disabled and running
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stop_ff <= 1'b0;
        end else if (clk_en) begin
            stop_ff <= drive_running & func.drive_enable_assigned & ~func.drive_enable;
        end
    end

    // Output selection, one instance per output terminal
    genvar g;
    generate
        for (g = 0; g < `DTF_NUM_OUT; g++) begin : g_out
            dtf_code_t sel;
            dtf_code_t base;
            logic inv;
            logic val;
            assign sel = out_func_select[g*`DTF_CODE_W +: `DTF_CODE_W];
            assign inv = (sel >= `DTF_OUT_INV_BASE) && (sel <= `DTF_OUT_MAX);
            assign base = inv ? dtf_code_t'(sel - `DTF_OUT_INV_BASE) : sel;
            // Status bit index equals code: 0 run, 11 fault, 36 enabled, etc.
            always_comb begin
                if (sel > `DTF_OUT_MAX || (!inv && base >= dtf_code_t'(`DTF_STAT_W))) begin
                    val = 1'b0;
                end else begin
                    val = drive_status[base[5:0]] ^ inv;
                end
            end
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    out_ff[g] <= 1'b0;
                end else if (clk_en) begin
                    out_ff[g] <= val;
                end
            end
        end
    endgenerate
endmodule

/* design/dtf_defs.svh */
// Purpose: Constants for the drive terminal function logic
// Assumes: 100 MHz sys_clk
// Notes: Function codes, widths, timing counts
`ifndef DTF_DEFS_SVH
`define DTF_DEFS_SVH
`define DTF_NUM_IN 8
`define DTF_NUM_OUT 4
`define DTF_CODE_W 8
`define DTF_FREQ_W 16
`define DTF_STAT_W 50
// Input function codes
`define DTF_IN_UP 8'h0A
`define DTF_IN_DOWN 8'h0B
`define DTF_IN_UP2 8'h0C
`define DTF_IN_DOWN2 8'h0D
`define DTF_IN_RAMP_HOLD 8'h12
`define DTF_IN_COMM 8'h2D
`define DTF_IN_PID_DIS 8'h2E
`define DTF_IN_INT_RST 8'h2F
`define DTF_IN_INT_HOLD 8'h30
`define DTF_IN_SOFT_OFF 8'h31
`define DTF_IN_OFS1 8'h35
`define DTF_IN_OFS2 8'h36
`define DTF_IN_OFS3 8'h37
`define DTF_IN_PGM_EN 8'h3C
`define DTF_IN_AHOLD 8'h3D
`define DTF_IN_DCB 8'h41
`define DTF_IN_DRV_EN 8'h45
// Output selection codes
`define DTF_OUT_INV_BASE 8'h64
`define DTF_OUT_MAX 8'h95
`define DTF_OUT_RELAY1_RST 8'h00
`define DTF_OUT_OTHER_RST 8'h00
// Analog hold qualify time
`define DTF_AHOLD_MS 100
`define DTF_CLK_MHZ 100
`define DTF_AHOLD_CYC (`DTF_AHOLD_MS * 1000 * `DTF_CLK_MHZ)
`endif

/* design/dtf_pkg.sv */
// Purpose: Types for the drive terminal function logic
// Assumes: dtf_defs.svh constants
// Notes: Status vector and decoded function bundle
`include "dtf_defs.svh"
package dtf_pkg;
    typedef logic [`DTF_CODE_W-1:0] dtf_code_t;
    typedef logic [`DTF_FREQ_W-1:0] dtf_freq_t;
    // Drive status conditions, bit index equals output code 0..49
    typedef logic [`DTF_STAT_W-1:0] dtf_status_t;
    // Decoded input functions
    typedef struct packed {
        logic pid_disable;
        logic integral_reset;
        logic integral_hold;
        logic soft_start_bypass;
        logic [2:0] offset_sel;
        logic program_enable;
        logic analog_hold;
        logic dc_brake;
        logic drive_enable;
        logic drive_enable_assigned;
    } dtf_func_t;
    typedef enum logic [1:0] {
        DTF_RUN_IDLE,
        DTF_RUN_ACTIVE,
        DTF_RUN_WAIT_CYCLE
    } dtf_run_state_t;
endpackage

/* verif/dtf_terminal_monitor.sv */
// Purpose: Port-level checks for the terminal function logic
// Assumes: clk_en is held high; pins pass a two-flop sync
// Notes: Keeps its own sync copy so decode checks line up in time
`timescale 1ns/1ns
`include "dtf_defs.svh"
module dtf_terminal_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [`DTF_NUM_IN-1:0] term_pin,
    input wire logic [`DTF_NUM_IN-1:0] comm_term,
    input wire logic [`DTF_NUM_IN*`DTF_CODE_W-1:0] in_func_select,
    input wire logic [`DTF_NUM_OUT*`DTF_CODE_W-1:0] out_func_select,
    input wire logic pid_enable_setting,
    input wire logic power_loss,
    input wire logic run_cmd,
    input wire logic jog_cmd,
    input wire logic drive_running,
    input wire logic param_write_req,
    input wire logic param_is_freq_monitor,
    input wire dtf_pkg::dtf_status_t drive_status,
    input wire logic pid_active,
    input wire logic pid_integral_clear,
    input wire logic pid_integral_freeze,
    input wire logic pid_ramp_bypass,
    input wire dtf_pkg::dtf_freq_t freq_command_out,
    input wire logic param_write_accept,
    input wire logic analog_hold_active,
    input wire logic setting_conflict_error,
    input wire logic dc_brake_apply,
    input wire logic run_permit,
    input wire logic stop_request,
    input wire logic drive_not_enabled_indication,
    input wire logic [`DTF_NUM_OUT-1:0] out_terminal
);
    import dtf_pkg::*;
    logic [7:0] s1_ff, sy_ff; // Sync copy of the pins
    wire [63:0] fs = in_func_select; // Short alias
    // Any terminal with code c whose level in p is closed
    function automatic logic cls(input dtf_code_t c, input logic [63:0] s, input logic [7:0] p);
        cls = 1'b0;
        for (int i = 0; i < 8; i++) if (s[8*i+:8] == c && p[i]) cls = 1'b1;
    endfunction
    // Expected outputs; reserved codes read open
    function automatic logic [3:0] omap(input logic [31:0] o, input dtf_status_t st);
        for (int k = 0; k < 4; k++) begin
            omap[k] = 1'b0;
            if (o[8*k+:8] < 8'h32) omap[k] = st[o[8*k+:8]];
            else if (o[8*k+:8] >= 8'h64 && o[8*k+:8] <= 8'h95) omap[k] = !st[o[8*k+:8]-8'h64];
        end
    endfunction
    // Two flops, matching the design's sync depth
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_ff <= 8'h00;
            sy_ff <= 8'h00;
        end else begin
            s1_ff <= term_pin;
            sy_ff <= s1_ff;
        end
    end
    wire [7:0] lv = cls(8'h2D, fs, 8'hFF) ? comm_term : sy_ff; // Comm mode swaps every terminal
    wire en_open = cls(8'h45, fs, 8'hFF) && !cls(8'h45, fs, lv); // Enable assigned but open
    wire mix = cls(8'h0A, fs, 8'hFF) || cls(8'h0B, fs, 8'hFF) || cls(8'h0C, fs, 8'hFF)
        || cls(8'h0D, fs, 8'hFF) || cls(8'h12, fs, 8'hFF) || cls(8'h35, fs, 8'hFF)
        || cls(8'h36, fs, 8'hFF) || cls(8'h37, fs, 8'hFF);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Losing enable while running must lead to a stop shortly after
    sequence run_lost;
        drive_running && en_open;
    endsequence
    pid_ctrl_a: assert property (pid_active == (pid_enable_setting && !cls(8'h2E, fs, lv)))
        else $error("pid_active wrong");
    integ_clear_a: assert property (pid_integral_clear == cls(8'h2F, fs, lv))
        else $error("integral clear wrong");
    integ_freeze_a: assert property (pid_integral_freeze == cls(8'h30, fs, lv))
        else $error("integral freeze wrong");
    ramp_bypass_a: assert property (pid_ramp_bypass == cls(8'h31, fs, lv))
        else $error("ramp bypass wrong");
    write_lock_a: assert property (param_write_accept == (param_write_req &&
        (!cls(8'h3C, fs, 8'hFF) || cls(8'h3C, fs, lv) || param_is_freq_monitor)))
        else $error("write accept wrong");
    conflict_err_a: assert property (setting_conflict_error == (cls(8'h3D, fs, 8'hFF) && mix))
        else $error("conflict flag wrong");
    hold_clear_a: assert property (!cls(8'h3D, fs, lv) |=> !analog_hold_active)
        else $error("hold kept while open");
    power_zero_a: assert property (power_loss |=> freq_command_out == 16'h0000)
        else $error("command not zero on power loss");
    dc_release_a: assert property ((run_cmd || jog_cmd) |=> !dc_brake_apply)
        else $error("braking kept on run");
    not_enabled_a: assert property (drive_not_enabled_indication == en_open)
        else $error("indication wrong");
    run_block_a: assert property (en_open [*3] |-> !run_permit)
        else $error("run allowed while not enabled");
    enable_stop_a: assert property (run_lost |-> ##[0:2] stop_request)
        else $error("no stop on enable loss");
    out_select_a: assert property (1'b1 |=> out_terminal == $past(omap(out_func_select, drive_status)))
        else $error("output terminal wrong");
endmodule

/* verif/dtf_switch_model.sv */
// Purpose: External contacts feeding the input terminals and the run command
// Assumes: Bench sets wanted contact states just after a clock edge
// Notes: Contacts move 1 ns after the edge, the same offset as all bench stimulus
`timescale 1ns/1ns
module dtf_switch_model (
    input wire logic sys_clk,
    input wire logic [7:0] want_closed,
    input wire logic want_run,
    output logic [7:0] term_pin,
    output logic run_cmd
);
    // All contacts open at power up
    initial begin
        term_pin = 8'h00;
        run_cmd = 1'b0;
    end
    // Movement off the edge exercises the pin sync instead of racing the edge
    always @(posedge sys_clk) begin
        term_pin <= #1 want_closed;
        run_cmd <= #1 want_run;
    end
endmodule

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the terminal function logic
// Assumes: Hold qualify time shortened to 20 cycles; clk_en tied high
// Notes: Expected values are worked out by hand from the function codes
`timescale 1ns/1ns
`include "dtf_defs.svh"
module tb_top;
    import dtf_pkg::*;
    localparam int HOLD_CYC = 20; // Short qualify time keeps the run brief
    logic sys_clk = 0, reset = 1, jog_cmd = 0, decel = 0, running = 0, pid_en = 1, ploss = 0;
    logic wreq = 0, wmon = 0, run_want = 0, asel = 1, run_cmd;
    logic [7:0] want = 8'h00, term_pin; // Wanted and actual contacts
    logic [7:0] comm = 8'h00; // Terminal states from the supervisory link
    logic [63:0] isel = 64'h453D3C3531302F2E; // Terminals 7..0
    logic [31:0] osel = 32'h0; // Outputs left at default first
    dtf_status_t status = 50'h1; // Running only
    dtf_freq_t ain1 = 16'h0555, ain2 = 16'h0ABC, fcmd = 16'h1000, output_frequency_detect;
    dtf_freq_t ofs1 = 16'h0010, ofs2 = 16'h0020, ofs3 = 16'h0030;
    logic pid_act, i_clr, i_frz, r_byp, w_acc, h_act, conf, dcb, permit, stop, no_en_ind;
    logic [3:0] oterm;
    dtf_code_t mixc [8] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h12, 8'h35, 8'h36, 8'h37};
    int err_total = 0, n_tests = 0, cyc = 0;
    dtf_terminal_logic #(.AHOLD_CYCLES(HOLD_CYC)) dtf_terminal_logic_inst (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .term_pin(term_pin), .comm_term(comm),
        .in_func_select(isel), .out_func_select(osel), .pid_enable_setting(pid_en),
        .power_loss(ploss), .run_cmd(run_cmd), .jog_cmd(jog_cmd), .decelerating(decel),
        .drive_running(running), .param_write_req(wreq), .param_is_freq_monitor(wmon),
        .analog_input_first(ain1), .analog_input_second(ain2), .analog_sel_second(asel),
        .offset_frequency_first(ofs1), .offset_frequency_second(ofs2),
        .offset_frequency_third(ofs3), .freq_command_in(fcmd), .drive_status(status),
        .pid_active(pid_act), .pid_integral_clear(i_clr), .pid_integral_freeze(i_frz),
        .pid_ramp_bypass(r_byp), .freq_command_out(output_frequency_detect), .param_write_accept(w_acc),
        .analog_hold_active(h_act), .setting_conflict_error(conf), .dc_brake_apply(dcb),
        .run_permit(permit), .stop_request(stop), .drive_not_enabled_indication(no_en_ind),
        .out_terminal(oterm));
    dtf_switch_model dtf_switch_model_inst (.sys_clk(sys_clk), .want_closed(want),
        .want_run(run_want), .term_pin(term_pin), .run_cmd(run_cmd));
    // 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Inputs always move 1 ns after an edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One contact, then enough edges for sync and output register
    task automatic pin(input int i, input logic v);
        want[i] = v;
        step(5);
    endtask
    task automatic code(input int i, input dtf_code_t c);
        isel[8*i+:8] = c;
        step(2);
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far above the roughly 150 cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        step(6);
        reset = 1'b0;
        step(3);
        chk("relay default", 4'hF, oterm);
        osel = 32'h3C16640B; // Reserved, reverse, inverse run, fault
        status = '1;
        step(2);
        chk("out all set", 4'h5, oterm);
        status = '0;
        step(2);
        chk("out all clear", 4'h2, oterm);
        chk("pid on", 1, pid_act);
        pin(0, 1);
        chk("pid off", 0, pid_act);
        pin(1, 1);
        chk("int clear", 1, i_clr);
        pin(2, 1);
        chk("int hold", 1, i_frz);
        pin(3, 1);
        chk("ramp bypass", 1, r_byp);
        want[3:0] = 4'h0;
        step(5);
        chk("pid idle", 4'h8, {pid_act, i_clr, i_frz, r_byp});
        comm = 8'h01;
        code(3, 8'h2D);
        chk("comm source", 0, pid_act);
        code(3, 8'h31);
        chk("comm released", 1, pid_act);
        chk("no offset", 16'h1000, output_frequency_detect);
        pin(4, 1);
        chk("offset one", 16'h1010, output_frequency_detect);
        code(4, 8'h37);
        chk("offset three", 16'h1030, output_frequency_detect);
        wreq = 1'b1;
        step(1);
        chk("locked write", 0, w_acc);
        wmon = 1'b1;
        step(1);
        chk("monitor write", 1, w_acc);
        wmon = 1'b0;
        pin(5, 1);
        chk("open write", 1, w_acc);
        // Every conflicting partner of the hold function
        foreach (mixc[k]) begin
            code(4, mixc[k]);
            chk("hold conflict", 1, conf);
        end
        code(4, 8'h41);
        chk("no conflict", 0, conf);
        decel = 1'b1;
        step(3);
        chk("brake on", 1, dcb);
        run_want = 1'b1;
        step(3);
        chk("brake run off", 0, dcb);
        run_want = 1'b0;
        step(3);
        chk("brake again", 1, dcb);
        jog_cmd = 1'b1;
        step(2);
        chk("brake jog off", 0, dcb);
        jog_cmd = 1'b0;
        decel = 1'b0;
        pin(4, 0);
        want[6] = 1'b1;
        step(HOLD_CYC / 2);
        chk("hold early", 0, h_act);
        step(HOLD_CYC);
        chk("hold on", 1, h_act);
        ain2 = 16'h0123;
        step(3);
        chk("hold level", 16'h0ABC, output_frequency_detect);
        ploss = 1'b1;
        step(2);
        chk("power cut", 16'h0000, output_frequency_detect);
        ploss = 1'b0;
        pin(6, 0);
        chk("not enabled", 1, no_en_ind);
        run_want = 1'b1;
        step(4);
        chk("run ignored", 0, permit);
        pin(7, 1);
        chk("run held", 0, permit);
        run_want = 1'b0;
        step(4);
        run_want = 1'b1;
        step(4);
        chk("run cycled", 1, permit);
        running = 1'b1;
        pin(7, 0);
        chk("enable lost", 1, stop);
        tally_and_finish();
    end
endmodule
bind dtf_terminal_logic dtf_terminal_monitor dtf_terminal_monitor_inst (.*);
